//--- core/startup_seq_pkg.sv
// Constants, types and register map for the clock start-up reset sequencer.
// Assumes a single 250 MHz system clock; oscillators arrive as sampled inputs.
package startup_seq_pkg;

    // ************************************************************
    // Register map (byte addresses on Avalon-MM)
    // ************************************************************
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] COUNTS_OFFSET = 4'h8;

    localparam int CTRL_SLEEP_BIT = 0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_RESET_BIT = 3;
    localparam int STATUS_MODE_LSB = 4;
    localparam int STATUS_SEL_BIT = 7;
    localparam int STATUS_SUT_LSB = 8;
    localparam int STATUS_TOUT_LSB = 10;
    localparam int STATUS_RANGE_LSB = 12;
    localparam int COUNTS_CNT_LSB = 16;

    localparam logic [31:0] READDATA_RESET = 32'h0000_0000;

    // ************************************************************
    // Counts
    // ************************************************************
    localparam logic [15:0] STARTUP_CK_6 = 16'h0006;
    localparam logic [15:0] STARTUP_CK_258 = 16'h0102;
    localparam logic [15:0] STARTUP_CK_1K = 16'h0400;
    localparam logic [15:0] RESET_EXTRA_CK = 16'h000E;
    localparam logic [1:0] SYNC_TICKS = 2'h2;

    // ************************************************************
    // Fuse encodings (1 = unprogrammed, 0 = programmed)
    // ************************************************************
    localparam logic [2:0] MODE_FULL_SWING = 3'h3;
    localparam logic [2:0] MODE_LOW_FREQ = 3'h2;
    localparam logic [2:0] FUSE_MODE_RESET = 3'h7;
    localparam logic [1:0] FUSE_SUT_RESET = 2'h3;

    typedef enum logic [1:0] {TOUT_NONE, TOUT_SHORT, TOUT_LONG} timeout_sel_t;

    typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_SYNC, ST_STARTUP, ST_RUN, ST_SLEEP}
        seq_state_t;

endpackage

//--- core/osc_edge_sync.sv
// Two-flop synchroniser plus rising-edge detector for one oscillator input.
// Assumes the oscillator is well below half the system clock rate.
`timescale 1ns/10ps
module osc_edge_sync (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic osc_in, // Raw oscillator level
    output logic tick // One-cycle pulse per oscillator rising edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } edge_state_t;

    edge_state_t state_reg;
    edge_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.meta = osc_in;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.sync & ~state_reg.prev;
endmodule // osc_edge_sync

//--- core/startup_fuse_decoder.sv
// Decodes the clock fuses into a start-up cycle count and a time-out choice.
// Assumes the fuse inputs are a held snapshot; purely combinational.
`timescale 1ns/10ps
module startup_fuse_decoder #(
    parameter logic [15:0] STARTUP_16K_CYCLES = 16'h4000,
    parameter logic [15:0] STARTUP_32K_CYCLES = 16'h8000
) (
    input wire logic [2:0] osc_mode_fuses, // Oscillator mode fuses
    input wire logic startup_select_fuse, // Start-up select fuse
    input wire logic [1:0] startup_time_fuses, // Start-up time fuses
    output logic [15:0] startup_cycles, // Oscillator cycles to count
    output startup_seq_pkg::timeout_sel_t timeout_sel, // Watchdog time-out choice
    output logic [1:0] osc_range // Low-power crystal frequency band
);
    always_comb begin
        startup_cycles = startup_seq_pkg::STARTUP_CK_6;
        timeout_sel = startup_seq_pkg::TOUT_LONG;
        osc_range = 2'h0;
        // Raw fuse bits taken as read: 1 unprogrammed, 0 programmed
        if (osc_mode_fuses[2] || osc_mode_fuses == startup_seq_pkg::MODE_FULL_SWING) begin
            if (osc_mode_fuses[2]) begin
                osc_range = osc_mode_fuses[1:0];
            end
            case ({startup_select_fuse, startup_time_fuses})
                3'h0: begin
                    startup_cycles = startup_seq_pkg::STARTUP_CK_258;
                    timeout_sel = startup_seq_pkg::TOUT_SHORT;
                end
                3'h1: begin
                    startup_cycles = startup_seq_pkg::STARTUP_CK_258;
                    timeout_sel = startup_seq_pkg::TOUT_LONG;
                end
                3'h2: begin
                    startup_cycles = startup_seq_pkg::STARTUP_CK_1K;
                    timeout_sel = startup_seq_pkg::TOUT_NONE;
                end
                3'h3: begin
                    startup_cycles = startup_seq_pkg::STARTUP_CK_1K;
                    timeout_sel = startup_seq_pkg::TOUT_SHORT;
                end
                3'h4: begin
                    startup_cycles = startup_seq_pkg::STARTUP_CK_1K;
                    timeout_sel = startup_seq_pkg::TOUT_LONG;
                end
                3'h5: begin
                    startup_cycles = STARTUP_16K_CYCLES;
                    timeout_sel = startup_seq_pkg::TOUT_NONE;
                end
                3'h6: begin
                    startup_cycles = STARTUP_16K_CYCLES;
                    timeout_sel = startup_seq_pkg::TOUT_SHORT;
                end
                default: begin
                    startup_cycles = STARTUP_16K_CYCLES;
                    timeout_sel = startup_seq_pkg::TOUT_LONG;
                end
            endcase
        end else if (osc_mode_fuses == startup_seq_pkg::MODE_LOW_FREQ) begin
            startup_cycles = startup_select_fuse ? STARTUP_32K_CYCLES
                                                 : startup_seq_pkg::STARTUP_CK_1K;
            case (startup_time_fuses)
                2'h0: timeout_sel = startup_seq_pkg::TOUT_NONE;
                2'h1: timeout_sel = startup_seq_pkg::TOUT_SHORT;
                default: timeout_sel = startup_seq_pkg::TOUT_LONG;
            endcase
        end else begin
            startup_cycles = startup_seq_pkg::STARTUP_CK_6;
            case (startup_time_fuses)
                2'h0: timeout_sel = startup_seq_pkg::TOUT_NONE;
                2'h1: timeout_sel = startup_seq_pkg::TOUT_SHORT;
                default: timeout_sel = startup_seq_pkg::TOUT_LONG;
            endcase
        end
    end
endmodule // startup_fuse_decoder

//--- core/clock_startup_reset_sequencer.sv
// Start-up sequencer: holds internal reset through time-out and oscillator start-up.
// Assumes oscillator and reset inputs are sampled on the 250 MHz system clock.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps

// Behaviour
// - Time-out starts after other resets release
// - Time-out counted on watchdog oscillator ticks
// - Time-out is 0, 4096 or 8192
// - Hold reset for oscillator start-up count
// - From reset: time-out plus start-up count
// - Wake from sleep: start-up count only
// - Start-up count spans 6 to 32K
// - Lower two mode fuses pick crystal frequency band
// - Select and time fuses pick counts
// - Select 0, time 00/01: 258 cycles
// - 1K cycles: none, short, long time-out
// - 16K cycles: none, short, long time-out
// - Reset adds 14 cycles plus time-out
// - Fuse one means unprogrammed, zero programmed
// - Full-swing crystal mode fuses equal 011
module clock_startup_reset_sequencer #(
    parameter logic [15:0] TIMEOUT_SHORT_CYCLES = 16'h1000,
    parameter logic [15:0] TIMEOUT_LONG_CYCLES = 16'h2000,
    parameter logic [15:0] STARTUP_16K_CYCLES = 16'h4000,
    parameter logic [15:0] STARTUP_32K_CYCLES = 16'h8000
) (
    input wire logic clock, // System clock, 250 MHz
    input wire logic rst, // Async reset, active high
    input wire logic ext_reset_active, // Any other reset source still active
    input wire logic wdt_osc, // Watchdog oscillator level
    input wire logic main_osc, // Selected main oscillator level
    input wire logic wake_event, // Wake from power-save or power-down
    input wire logic [2:0] osc_mode_fuses, // Oscillator mode fuses
    input wire logic startup_select_fuse, // Start-up select fuse
    input wire logic [1:0] startup_time_fuses, // Start-up time fuses
    input wire logic [3:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait request
    output logic internal_reset // Internal reset, active high
);
    typedef struct packed {
        startup_seq_pkg::seq_state_t state;
        logic [15:0] cnt;
        logic [1:0] sync_cnt;
        logic from_wake;
        logic [2:0] mode;
        logic sel;
        logic [1:0] sut;
        logic internal_reset;
        logic waitrequest;
        logic [31:0] readdata;
    } seq_regs_t;

    seq_regs_t state_reg;
    seq_regs_t state_next;

    logic wdt_tick;
    logic main_tick;
    logic [15:0] startup_cycles;
    startup_seq_pkg::timeout_sel_t timeout_sel;
    logic [1:0] osc_range;
    logic [15:0] timeout_limit;
    logic [15:0] start_limit;
    logic bus_req;
    logic bus_take;
    logic bus_done;

    // ************************************************************
    // Oscillator edge detection
    // ************************************************************
    osc_edge_sync wdt_sync (
        .clock(clock),
        .rst(rst),
        .osc_in(wdt_osc),
        .tick(wdt_tick)
    );

    osc_edge_sync main_sync (
        .clock(clock),
        .rst(rst),
        .osc_in(main_osc),
        .tick(main_tick)
    );

    // ************************************************************
    // Fuse decode from the held snapshot
    // ************************************************************
    startup_fuse_decoder #(
        .STARTUP_16K_CYCLES(STARTUP_16K_CYCLES),
        .STARTUP_32K_CYCLES(STARTUP_32K_CYCLES)
    ) decoder (
        .osc_mode_fuses(state_reg.mode),
        .startup_select_fuse(state_reg.sel),
        .startup_time_fuses(state_reg.sut),
        .startup_cycles(startup_cycles),
        .timeout_sel(timeout_sel),
        .osc_range(osc_range)
    );

    function automatic logic [15:0] timeout_cycles(input startup_seq_pkg::timeout_sel_t sel);
        case (sel)
            startup_seq_pkg::TOUT_SHORT: timeout_cycles = TIMEOUT_SHORT_CYCLES;
            startup_seq_pkg::TOUT_LONG: timeout_cycles = TIMEOUT_LONG_CYCLES;
            default: timeout_cycles = 16'h0000;
        endcase
    endfunction

    assign timeout_limit = timeout_cycles(timeout_sel);
    // Wake skips the 14 extra cycles and the time-out
    assign start_limit = 16'(startup_cycles + (state_reg.from_wake ? 16'h0000
                                               : startup_seq_pkg::RESET_EXTRA_CK));
    assign bus_req = read | write;
    assign bus_take = bus_req & state_reg.waitrequest;
    assign bus_done = bus_req & ~state_reg.waitrequest;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg.state)
            startup_seq_pkg::ST_HOLD: begin
                state_next.internal_reset = 1'b1;
                if (!ext_reset_active) begin
                    state_next.mode = osc_mode_fuses;
                    state_next.sel = startup_select_fuse;
                    state_next.sut = startup_time_fuses;
                    state_next.from_wake = 1'b0;
                    state_next.cnt = 16'h0000;
                    state_next.state = startup_seq_pkg::ST_TIMEOUT;
                end
            end
            startup_seq_pkg::ST_TIMEOUT: begin
                if (timeout_limit == 16'h0000) begin
                    state_next.sync_cnt = 2'h0;
                    state_next.state = startup_seq_pkg::ST_SYNC;
                end else if (wdt_tick) begin
                    if (state_reg.cnt == 16'(timeout_limit - 16'h0001)) begin
                        state_next.cnt = 16'h0000;
                        state_next.sync_cnt = 2'h0;
                        state_next.state = startup_seq_pkg::ST_SYNC;
                    end else begin
                        state_next.cnt = 16'(state_reg.cnt + 16'h0001);
                    end
                end
            end
            startup_seq_pkg::ST_SYNC: begin
                // Completion must be seen on main oscillator edges first
                if (main_tick) begin
                    if (state_reg.sync_cnt == 2'(startup_seq_pkg::SYNC_TICKS - 2'h1)) begin
                        state_next.cnt = 16'h0000;
                        state_next.state = startup_seq_pkg::ST_STARTUP;
                    end else begin
                        state_next.sync_cnt = 2'(state_reg.sync_cnt + 2'h1);
                    end
                end
            end
            startup_seq_pkg::ST_STARTUP: begin
                state_next.internal_reset = 1'b1;
                if (main_tick) begin
                    if (state_reg.cnt == 16'(start_limit - 16'h0001)) begin
                        state_next.internal_reset = 1'b0;
                        state_next.state = startup_seq_pkg::ST_RUN;
                    end else begin
                        state_next.cnt = 16'(state_reg.cnt + 16'h0001);
                    end
                end
            end
            startup_seq_pkg::ST_RUN: begin
                state_next.internal_reset = 1'b0;
                if (bus_done && write && address == startup_seq_pkg::CTRL_OFFSET
                        && byteenable[0] && writedata[startup_seq_pkg::CTRL_SLEEP_BIT]) begin
                    state_next.internal_reset = 1'b1;
                    state_next.state = startup_seq_pkg::ST_SLEEP;
                end
            end
            startup_seq_pkg::ST_SLEEP: begin
                state_next.internal_reset = 1'b1;
                if (wake_event) begin
                    state_next.mode = osc_mode_fuses;
                    state_next.sel = startup_select_fuse;
                    state_next.sut = startup_time_fuses;
                    state_next.from_wake = 1'b1;
                    state_next.cnt = 16'h0000;
                    state_next.state = startup_seq_pkg::ST_STARTUP;
                end
            end
            default: begin
                state_next.state = startup_seq_pkg::ST_HOLD;
            end
        endcase
        if (ext_reset_active) begin
            state_next.internal_reset = 1'b1;
            state_next.cnt = 16'h0000;
            state_next.state = startup_seq_pkg::ST_HOLD;
        end

        // Avalon slave: one wait cycle, then answer
        state_next.waitrequest = ~bus_take;
        if (bus_take && read) begin
            state_next.readdata = 32'h0000_0000;
            case (address)
                startup_seq_pkg::STATUS_OFFSET: begin
                    state_next.readdata[startup_seq_pkg::STATUS_STATE_LSB +: 3] =
                        state_reg.state;
                    state_next.readdata[startup_seq_pkg::STATUS_RESET_BIT] =
                        state_reg.internal_reset;
                    state_next.readdata[startup_seq_pkg::STATUS_MODE_LSB +: 3] = state_reg.mode;
                    state_next.readdata[startup_seq_pkg::STATUS_SEL_BIT] = state_reg.sel;
                    state_next.readdata[startup_seq_pkg::STATUS_SUT_LSB +: 2] = state_reg.sut;
                    state_next.readdata[startup_seq_pkg::STATUS_TOUT_LSB +: 2] = timeout_sel;
                    state_next.readdata[startup_seq_pkg::STATUS_RANGE_LSB +: 2] = osc_range;
                end
                startup_seq_pkg::COUNTS_OFFSET: begin
                    state_next.readdata[15:0] = startup_cycles;
                    state_next.readdata[startup_seq_pkg::COUNTS_CNT_LSB +: 16] = state_reg.cnt;
                end
                default: begin
                    state_next.readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg.state <= startup_seq_pkg::ST_HOLD;
            state_reg.cnt <= 16'h0000;
            state_reg.sync_cnt <= 2'h0;
            state_reg.from_wake <= 1'b0;
            state_reg.mode <= startup_seq_pkg::FUSE_MODE_RESET;
            state_reg.sel <= 1'b1;
            state_reg.sut <= startup_seq_pkg::FUSE_SUT_RESET;
            state_reg.internal_reset <= 1'b1;
            state_reg.waitrequest <= 1'b1;
            state_reg.readdata <= startup_seq_pkg::READDATA_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign readdata = state_reg.readdata;
    assign waitrequest = state_reg.waitrequest;
    assign internal_reset = state_reg.internal_reset;

    // ************************************************************
    // Checks
    // ************************************************************
    a_hold_ext_reset: assert property (
        @(posedge clock) disable iff (rst)
        ext_reset_active |=> internal_reset && state_reg.state == startup_seq_pkg::ST_HOLD)
        else $error("internal reset not held while another reset is active");

    a_timeout_wdt_only: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.state == startup_seq_pkg::ST_TIMEOUT
         && $past(state_reg.state) == startup_seq_pkg::ST_TIMEOUT && $changed(state_reg.cnt))
        |-> $past(wdt_tick))
        else $error("time-out counter moved without a watchdog tick");

    a_timeout_bound: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.state == startup_seq_pkg::ST_TIMEOUT && timeout_limit != 16'h0000)
        |-> state_reg.cnt < timeout_limit)
        else $error("time-out counter passed its limit");

    a_release_count: assert property (
        @(posedge clock) disable iff (rst)
        $fell(internal_reset) |-> $past(state_reg.cnt) == 16'($past(start_limit) - 16'h0001)
                                  && $past(main_tick))
        else $error("reset released before start-up count completed");

    a_reset_path: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.state == startup_seq_pkg::ST_HOLD && !ext_reset_active)
        |=> state_reg.state == startup_seq_pkg::ST_TIMEOUT && !state_reg.from_wake)
        else $error("reset path skipped the time-out");

    a_wake_skip: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.state == startup_seq_pkg::ST_SLEEP && wake_event && !ext_reset_active)
        |=> state_reg.state == startup_seq_pkg::ST_STARTUP && state_reg.from_wake
            && state_reg.cnt == 16'h0000)
        else $error("wake did not go straight to start-up count");

    a_count_range: assert property (
        @(posedge clock) disable iff (rst)
        startup_cycles >= startup_seq_pkg::STARTUP_CK_6 && startup_cycles <= STARTUP_32K_CYCLES)
        else $error("start-up count outside supported range");

    a_lp_258: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.mode[2] && !state_reg.sel && !state_reg.sut[1])
        |-> startup_cycles == startup_seq_pkg::STARTUP_CK_258
            && timeout_sel == (state_reg.sut[0] ? startup_seq_pkg::TOUT_LONG
                                                : startup_seq_pkg::TOUT_SHORT))
        else $error("258-cycle fuse setting decoded wrongly");

    a_sync_wait: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.state == startup_seq_pkg::ST_STARTUP
         && $past(state_reg.state) == startup_seq_pkg::ST_SYNC)
        |-> $past(state_reg.sync_cnt) == 2'(startup_seq_pkg::SYNC_TICKS - 2'h1)
            && $past(main_tick))
        else $error("start-up began before time-out completion was synchronised");

    a_fuse_held: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg.state inside {startup_seq_pkg::ST_TIMEOUT, startup_seq_pkg::ST_SYNC,
                                 startup_seq_pkg::ST_STARTUP}
         && $past(state_reg.state) inside {startup_seq_pkg::ST_TIMEOUT,
                                           startup_seq_pkg::ST_SYNC,
                                           startup_seq_pkg::ST_STARTUP})
        |-> $stable({state_reg.mode, state_reg.sel, state_reg.sut}))
        else $error("fuse snapshot changed during start-up");
endmodule // clock_startup_reset_sequencer

//--- dv/osc_partner.sv
// Oscillator model: main and watchdog oscillators, four system clocks a period.
// Assumes a free-running system clock; the watchdog can be stopped by the bench.
`timescale 1ns/10ps
module osc_partner (
    input wire logic clock, // System clock
    input wire logic wdt_en, // Watchdog oscillator runs while high
    output logic wdt_osc, // Watchdog oscillator level
    output logic main_osc // Main oscillator level
);
    logic [1:0] phase_reg = 2'h0;
    always @(posedge clock) phase_reg <= phase_reg + 2'h1;
    assign main_osc = phase_reg[1];
    assign wdt_osc = wdt_en & phase_reg[1];
endmodule // osc_partner

//--- dv/testbench.sv
// Self-checking bench: fuse table runs from reset, then a sleep and wake.
// Assumes short time-outs 8/16 and start-up counts 2048/4096 given below.
`timescale 1ns/10ps
module testbench;
    logic clock = 1'b0, rst = 1'b1, ext_reset_active = 1'b1, wake_event = 1'b0, wdt_en = 1'b1;
    logic wdt_osc, main_osc, read = 1'b0, write = 1'b0, waitrequest, internal_reset;
    logic [2:0] osc_mode_fuses = 3'h7, m;
    logic startup_select_fuse = 1'b1;
    logic [1:0] startup_time_fuses = 2'h3;
    logic [3:0] address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [15:0] ec [8] = '{16'h0102, 16'h0102, 16'h0400, 16'h0400, 16'h0400,
        16'h0800, 16'h0800, 16'h0800};
    logic [1:0] tt [8] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    int num_errors = 0, compares = 0, n, lo;
    osc_partner osc (.clock(clock), .wdt_en(wdt_en), .wdt_osc(wdt_osc), .main_osc(main_osc));
    clock_startup_reset_sequencer #(.TIMEOUT_SHORT_CYCLES(16'h0008),
        .TIMEOUT_LONG_CYCLES(16'h0010), .STARTUP_16K_CYCLES(16'h0800),
        .STARTUP_32K_CYCLES(16'h1000)) uut (.clock(clock), .rst(rst),
        .ext_reset_active(ext_reset_active), .wdt_osc(wdt_osc), .main_osc(main_osc),
        .wake_event(wake_event), .osc_mode_fuses(osc_mode_fuses),
        .startup_select_fuse(startup_select_fuse), .startup_time_fuses(startup_time_fuses),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .internal_reset(internal_reset));
    initial forever #2 clock = ~clock;
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= d;
        // Only the watchdog ends a wait that never sees waitrequest low
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_release(input int limit);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (internal_reset !== 1'b0 && n < limit);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        tally_and_finish();
    end
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(1'b0, 4'h4, 32'h0);
        chk("status_after_reset", 32'h000003F8, {22'h0, q[9:0]});
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped_read", 32'h0, q);
        $display("test reset_state done");
        for (int i = 0; i < 8; i++) begin
            m = (i < 7) ? (3'h4 + 3'(i % 4)) : 3'h3;
            ext_reset_active <= 1'b1;
            osc_mode_fuses <= m;
            {startup_select_fuse, startup_time_fuses} <= i[2:0];
            repeat (3) @(posedge clock);
            chk("reset_held", 32'h1, {31'h0, internal_reset});
            ext_reset_active <= 1'b0;
            @(posedge clock);
            osc_mode_fuses <= 3'h7;
            {startup_select_fuse, startup_time_fuses} <= 3'h7;
            wait_release(9000);
            // Time-out, 2-tick sync and start-up ticks, 4 clocks a tick, plus tick latency
            lo = (int'(ec[i]) + 14 + 8 * int'(tt[i])) * 4;
            chk("release_delay", 32'h1, 32'(n >= lo && n <= lo + 12));
            bus(1'b0, 4'h8, 32'h0);
            chk("startup_count", {16'h0, ec[i]}, {16'h0, q[15:0]});
            bus(1'b0, 4'h4, 32'h0);
            chk("status_run", {18'h0, m[2] ? m[1:0] : 2'h0, tt[i], i[1:0], i[2], m, 4'h4},
                {18'h0, q[13:0]});
            $display("test fuse_combo %0d done", i);
        end
        byteenable <= 4'h0;
        bus(1'b1, 4'h0, 32'h1);
        byteenable <= 4'hF;
        bus(1'b0, 4'h4, 32'h0);
        chk("ctrl_be_ignored", 32'h4, {29'h0, q[2:0]});
        wdt_en <= 1'b0;
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b0, 4'h4, 32'h0);
        chk("sleep_state", 32'hD, {28'h0, q[3:0]});
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        wait_release(9000);
        // 2048 ticks only: no 14 extra ticks, no time-out
        lo = 2048 * 4;
        chk("wake_no_timeout", 32'h1, 32'(n >= lo - 2 && n <= lo + 2));
        $display("test sleep_wake done");
        tally_and_finish();
    end
endmodule // testbench
